// file: rtl/mrm_pkg.sv
package mrm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int MRM_DATA_W = 8;
    localparam int MRM_ADDR_W = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] MRM_ADDR_MAKER_ID = 8'h3e;
    localparam logic [7:0] MRM_ADDR_VERSION = 8'h3f;
    localparam logic [7:0] MRM_ADDR_CONFIG = 8'h40;
    localparam logic [7:0] MRM_ADDR_STATUS = 8'h41;
    localparam logic [7:0] MRM_ADDR_RSVD_A = 8'h42;
    localparam logic [7:0] MRM_ADDR_MASK = 8'h43;
    localparam logic [7:0] MRM_ADDR_RSVD_B = 8'h44;
    localparam logic [7:0] MRM_ADDR_RSVD_C = 8'h47;
    localparam logic [7:0] MRM_ADDR_RSVD_D = 8'h4a;
    localparam logic [7:0] MRM_ADDR_STATUS_COPY = 8'h4c;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration field positions
    localparam int MRM_CFG_START_BIT = 0;
    localparam int MRM_CFG_INT_EN_BIT = 1;
    localparam int MRM_CFG_INT_CLR_BIT = 2;
    localparam int MRM_CFG_LOCK_BIT = 3;
    localparam int MRM_CFG_SOFT_RST_BIT = 4;

    // version field positions
    localparam int MRM_VER_STEP_LSB = 0;
    localparam int MRM_VER_CODE_LSB = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0] MRM_CONFIG_RESET = 8'h25;
    localparam logic [7:0] MRM_STATUS_RESET = 8'h00;
    localparam logic [7:0] MRM_MASK_RESET = 8'h00;
    localparam logic [7:0] MRM_STATUS_COPY_RESET = 8'h00;
    localparam logic [7:0] MRM_RDATA_RESET = 8'h00;
    localparam logic [7:0] MRM_ZERO_BYTE = 8'h00;
    localparam logic [7:0] MRM_ALL_ONES = 8'hff;

    ////////////////////////////////////////////////////////////////////////////////
    // state types
    typedef struct packed {
        logic [7:0] config_bits;
        logic [7:0] mask_bits;
        logic [7:0] rdata;
        logic rvalid;
    } mrm_regs_type;

    typedef struct packed {
        logic [7:0] bits;
    } mrm_sticky_type;

    typedef struct packed {
        logic int_b;
    } mrm_pin_type;

endpackage

// file: rtl/mrm_sticky_bits.sv
`timescale 1ns/10ps

module mrm_sticky_bits import mrm_pkg::*; #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_set,
    input wire logic [7:0] i_clr,
    output logic [7:0] o_bits
);

    mrm_sticky_type state_q;
    mrm_sticky_type state_d;

    ////////////////////////////////////////////////////////////////////////////////
    // set wins over clear
    always_comb begin
        state_d = state_q;
        state_d.bits = (state_q.bits & ~i_clr) | i_set;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q.bits <= RESET_VALUE;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_bits = state_q.bits;

endmodule

// file: rtl/mrm_irq_pin.sv
`timescale 1ns/10ps

module mrm_irq_pin import mrm_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_enable,
    input wire logic i_clear,
    input wire logic i_pending,
    output logic o_int_b
);

    mrm_pin_type state_q;
    mrm_pin_type state_d;

    ////////////////////////////////////////////////////////////////////////////////
    // pin drive
    always_comb begin
        state_d = state_q;
        state_d.int_b = ~(i_enable & ~i_clear & i_pending);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q.int_b <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_int_b = state_q.int_b;

endmodule

// file: rtl/mrm_regs.sv
`timescale 1ns/10ps

// What this block does
// - interrupt pin stays inactive after power-up until software enables it
// - enable set but clear set: events recorded, pin does not toggle
// - maker identification byte at 0x3E is read only, writes ignored
// - register 0x3F returns stepping number in bits 3 to 0
// - register 0x3F bits 7 to 4 return fixed product version code
// - configuration register loads 0010 0101 at power-on reset
// - interrupt status register at 0x41 resets to zero
// - interrupt mask register at 0x43 resets to zero, all unmasked
// - status mirror register at 0x4C resets to zero
// - 0x42, 0x44, 0x47, 0x4A reserved, no function implemented there
// - pin active only while enable bit one and clear bit zero
module mrm_regs import mrm_pkg::*; #(
    // arbitrary neutral identity values
    parameter logic [7:0] MAKER_ID = 8'h5a,
    parameter logic [3:0] VERSION_CODE = 4'h3,
    parameter logic [3:0] STEPPING = 4'h0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic [7:0] i_irq_event,
    output logic o_int_b,
    output logic o_start,
    output logic o_trip_lock,
    output logic [7:0] o_irq_status
);

    ////////////////////////////////////////////////////////////////////////////////
    // state and wires
    mrm_regs_type state_q;
    mrm_regs_type state_d;

    logic [7:0] status_bits;
    logic [7:0] status_copy_bits;
    logic [7:0] status_clr;
    logic [7:0] status_copy_clr;
    logic [7:0] version_byte;
    logic [7:0] read_value;
    logic hit_maker_id;
    logic hit_version;
    logic hit_config;
    logic hit_status;
    logic hit_mask;
    logic hit_status_copy;
    logic hit_reserved;
    logic wr_config;
    logic wr_mask;
    logic soft_reset;
    logic irq_pending;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode
    always_comb begin
        hit_maker_id = 1'b0;
        hit_version = 1'b0;
        hit_config = 1'b0;
        hit_status = 1'b0;
        hit_mask = 1'b0;
        hit_status_copy = 1'b0;
        hit_reserved = 1'b0;
        case (i_reg_addr)
            MRM_ADDR_MAKER_ID: begin
                hit_maker_id = 1'b1;
            end
            MRM_ADDR_VERSION: begin
                hit_version = 1'b1;
            end
            MRM_ADDR_CONFIG: begin
                hit_config = 1'b1;
            end
            MRM_ADDR_STATUS: begin
                hit_status = 1'b1;
            end
            MRM_ADDR_MASK: begin
                hit_mask = 1'b1;
            end
            MRM_ADDR_STATUS_COPY: begin
                hit_status_copy = 1'b1;
            end
            MRM_ADDR_RSVD_A, MRM_ADDR_RSVD_B, MRM_ADDR_RSVD_C, MRM_ADDR_RSVD_D: begin
                hit_reserved = 1'b1;
            end
            default: begin
                hit_reserved = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write strobes
    always_comb begin
        wr_config = i_reg_wr & hit_config;
        wr_mask = i_reg_wr & hit_mask;
        soft_reset = wr_config & i_reg_wdata[MRM_CFG_SOFT_RST_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data
    always_comb begin
        version_byte = {VERSION_CODE, STEPPING};
        read_value = MRM_ZERO_BYTE;
        if (hit_maker_id) begin
            read_value = MAKER_ID;
        end else if (hit_version) begin
            read_value = version_byte;
        end else if (hit_config) begin
            read_value = state_q.config_bits;
        end else if (hit_status) begin
            read_value = status_bits;
        end else if (hit_mask) begin
            read_value = state_q.mask_bits;
        end else if (hit_status_copy) begin
            read_value = status_copy_bits;
        end else begin
            read_value = MRM_ZERO_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status clears
    always_comb begin
        status_clr = MRM_ZERO_BYTE;
        status_copy_clr = MRM_ZERO_BYTE;
        if (soft_reset) begin
            status_clr = MRM_ALL_ONES;
            status_copy_clr = MRM_ALL_ONES;
        end else begin
            if (i_reg_rd && hit_status) begin
                status_clr = MRM_ALL_ONES;
            end
            if (i_reg_rd && hit_status_copy) begin
                status_copy_clr = MRM_ALL_ONES;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_d = state_q;
        state_d.rvalid = i_reg_rd;
        if (i_reg_rd) begin
            state_d.rdata = read_value;
        end
        if (soft_reset) begin
            // back to power-on values, soft reset bit self-clears
            state_d.config_bits = MRM_CONFIG_RESET;
            state_d.mask_bits = MRM_MASK_RESET;
        end else begin
            if (wr_config) begin
                state_d.config_bits = i_reg_wdata;
                state_d.config_bits[MRM_CFG_LOCK_BIT] =
                    i_reg_wdata[MRM_CFG_LOCK_BIT] | state_q.config_bits[MRM_CFG_LOCK_BIT];
                state_d.config_bits[MRM_CFG_SOFT_RST_BIT] = 1'b0;
            end
            if (wr_mask) begin
                state_d.mask_bits = i_reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q.config_bits <= MRM_CONFIG_RESET;
            state_q.mask_bits <= MRM_MASK_RESET;
            state_q.rdata <= MRM_RDATA_RESET;
            state_q.rvalid <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status and mirror
    // status cleared at reset
    mrm_sticky_bits #(
        .RESET_VALUE(MRM_STATUS_RESET)
    ) u_status (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_set(i_irq_event),
        .i_clr(status_clr),
        .o_bits(status_bits)
    );

    mrm_sticky_bits #(
        .RESET_VALUE(MRM_STATUS_COPY_RESET)
    ) u_status_copy (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_set(i_irq_event),
        .i_clr(status_copy_clr),
        .o_bits(status_copy_bits)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt pin
    always_comb begin
        irq_pending = |(status_bits & ~state_q.mask_bits);
    end

    mrm_irq_pin u_irq_pin (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_enable(state_q.config_bits[MRM_CFG_INT_EN_BIT]),
        .i_clear(state_q.config_bits[MRM_CFG_INT_CLR_BIT]),
        .i_pending(irq_pending),
        .o_int_b(o_int_b)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_reg_rdata = state_q.rdata;
    assign o_reg_rvalid = state_q.rvalid;
    assign o_start = state_q.config_bits[MRM_CFG_START_BIT];
    assign o_trip_lock = state_q.config_bits[MRM_CFG_LOCK_BIT];
    assign o_irq_status = status_bits;

endmodule

// file: verif/mrm_regs_chk.sv
`timescale 1ns/10ps
module mrm_regs_chk import mrm_pkg::*; #(
    parameter logic [7:0] MAKER_ID = 8'h5a,
    parameter logic [3:0] VERSION_CODE = 4'h3,
    parameter logic [3:0] STEPPING = 4'h0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic [7:0] i_irq_event,
    input wire logic o_int_b,
    input wire logic o_start,
    input wire logic o_trip_lock,
    input wire logic [7:0] o_irq_status
);
    logic [7:0] cfg_q;
    logic [7:0] mask_q;
    logic cfg_wr;
    logic ev_on;
    logic rsvd;
    assign cfg_wr = i_reg_wr && i_reg_addr == MRM_ADDR_CONFIG;
    assign ev_on = |(i_irq_event & ~mask_q) && cfg_q[1] && !cfg_q[2] && !i_reg_wr;
    assign rsvd = i_reg_addr inside {8'h42, 8'h44, 8'h47, 8'h4a};
    // shadow of pin gating bits
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b || (cfg_wr && i_reg_wdata[4])) begin
            cfg_q <= 8'h25;
            mask_q <= 8'h00;
        end else if (cfg_wr) begin
            cfg_q <= i_reg_wdata;
        end else if (i_reg_wr && i_reg_addr == MRM_ADDR_MASK) begin
            mask_q <= i_reg_wdata;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    property p_maker_id;
        i_reg_rd && i_reg_addr == 8'h3e |=> o_reg_rvalid && o_reg_rdata == MAKER_ID;
    endproperty
    a_maker_id: assert property (p_maker_id)
        else $error("maker byte wrong");
    property p_version;
        i_reg_rd && i_reg_addr == 8'h3f |=> o_reg_rdata == {VERSION_CODE, STEPPING};
    endproperty
    a_version: assert property (p_version)
        else $error("version byte wrong");
    property p_rsvd_zero;
        i_reg_rd && rsvd |=> o_reg_rvalid && o_reg_rdata == 8'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved read not zero");
    property p_pin_gate;
        !o_int_b |-> $past(cfg_q[1]) && !$past(cfg_q[2]);
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("pin active while gated");
    property p_pin_fire;
        ev_on |-> ##2 !o_int_b;
    endproperty
    a_pin_fire: assert property (p_pin_fire)
        else $error("pin not driven");
    property p_ev_record;
        |i_irq_event |=> (o_irq_status & $past(i_irq_event)) == $past(i_irq_event);
    endproperty
    a_ev_record: assert property (p_ev_record)
        else $error("event not recorded");
    property p_status_rd;
        i_reg_rd && i_reg_addr == 8'h41 && i_irq_event == 8'h00
            |=> o_reg_rdata == $past(o_irq_status) && o_irq_status == 8'h00;
    endproperty
    a_status_rd: assert property (p_status_rd)
        else $error("status read wrong");
    property p_reset_vals;
        $rose(i_rst_b) |-> o_int_b && o_start && !o_trip_lock && o_irq_status == 8'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset state wrong");
    c_pin_low: cover property ($fell(o_int_b));
    c_soft_rst: cover property (cfg_wr && i_reg_wdata[4]);
    c_rsvd_rd: cover property (i_reg_rd && rsvd);
endmodule
bind mrm_regs mrm_regs_chk #(.MAKER_ID(MAKER_ID), .VERSION_CODE(VERSION_CODE),
    .STEPPING(STEPPING)) u_chk (.i_ref_clk, .i_rst_b, .i_reg_addr, .i_reg_wr,
    .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_irq_event, .o_int_b,
    .o_start, .o_trip_lock, .o_irq_status);

// file: verif/mrm_host_model.sv
`timescale 1ns/10ps
module mrm_host_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata,
    output logic o_rd
);
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_ref_clk);
        #1;
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge i_ref_clk);
        #1;
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_ref_clk);
        #1;
        o_rd = 1'b0;
        o_addr = ~a;
        ok = i_rvalid;
        d = i_rdata;
    endtask
endmodule

// file: verif/mrm_regs_tb.sv
`timescale 1ns/10ps
module mrm_regs_tb import mrm_pkg::*; ;
    // arbitrary identity values
    localparam logic [7:0] MAKER = 8'ha7;
    localparam logic [3:0] VER = 4'h2;
    localparam logic [3:0] STEP = 4'h1;
    localparam logic [7:0] RSVD [5] = '{8'h42, 8'h44, 8'h47, 8'h4a, 8'h50};
    logic clk, rst_b, wr, rd, rvalid, int_b, start, lock;
    logic [7:0] addr, wdata, rdata, ev, status;
    int compares = 0;
    int mismatches = 0;
    int cycles = 0;
    mrm_regs #(.MAKER_ID(MAKER), .VERSION_CODE(VER), .STEPPING(STEP)) u_dut (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_irq_event(ev), .o_int_b(int_b), .o_start(start), .o_trip_lock(lock),
        .o_irq_status(status));
    mrm_host_model u_host (.i_ref_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd));
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            print_verdict;
        end
    end
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        u_host.rd(a, d, ok);
        cmp8({7'h00, ok}, 8'h01);
        cmp8(d, exp);
    endtask
    task automatic pin_after(input logic exp);
        @(posedge clk);
        #1;
        cmp8({7'h00, int_b}, {7'h00, exp});
    endtask
    task automatic pulse(input logic [7:0] e);
        @(posedge clk);
        #1;
        ev = e;
        @(posedge clk);
        #1;
        ev = 8'h00;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        cmp8({7'h00, int_b}, 8'h01);
        chk_rd(MRM_ADDR_CONFIG, 8'h25);
        chk_rd(MRM_ADDR_STATUS, 8'h00);
        chk_rd(MRM_ADDR_MASK, 8'h00);
        chk_rd(MRM_ADDR_STATUS_COPY, 8'h00);
    endtask
    task automatic t_identity;
        u_host.wr(MRM_ADDR_MAKER_ID, ~MAKER);
        chk_rd(MRM_ADDR_MAKER_ID, MAKER);
        u_host.wr(MRM_ADDR_VERSION, 8'h00);
        chk_rd(MRM_ADDR_VERSION, {VER, STEP});
    endtask
    task automatic t_reserved;
        foreach (RSVD[i]) begin
            u_host.wr(RSVD[i], 8'hff);
            chk_rd(RSVD[i], 8'h00);
        end
        chk_rd(MRM_ADDR_CONFIG, 8'h25);
        chk_rd(MRM_ADDR_MASK, 8'h00);
    endtask
    task automatic t_clear_holds;
        u_host.wr(MRM_ADDR_CONFIG, 8'h07);
        pulse(8'h04);
        cmp8(status, 8'h04);
        repeat (3) pin_after(1'b1);
        chk_rd(MRM_ADDR_STATUS, 8'h04);
        chk_rd(MRM_ADDR_STATUS_COPY, 8'h04);
    endtask
    task automatic t_enable;
        u_host.wr(MRM_ADDR_CONFIG, 8'h03);
        pin_after(1'b1);
        pulse(8'h20);
        pin_after(1'b0);
        chk_rd(MRM_ADDR_STATUS, 8'h20);
        pin_after(1'b1);
        u_host.wr(MRM_ADDR_MASK, 8'h01);
        pulse(8'h01);
        repeat (2) pin_after(1'b1);
        pulse(8'h02);
        pin_after(1'b0);
        u_host.wr(MRM_ADDR_CONFIG, 8'h07);
        pin_after(1'b1);
        cmp8(status, 8'h03);
        chk_rd(MRM_ADDR_STATUS_COPY, 8'h23);
        u_host.wr(MRM_ADDR_CONFIG, 8'h10);
        cmp8(status, 8'h00);
        chk_rd(MRM_ADDR_CONFIG, 8'h25);
        chk_rd(MRM_ADDR_MASK, 8'h00);
    endtask
    task automatic t_lock;
        u_host.wr(MRM_ADDR_CONFIG, 8'h2c);
        cmp8({6'h00, lock, start}, 8'h02);
        u_host.wr(MRM_ADDR_CONFIG, 8'h25);
        chk_rd(MRM_ADDR_CONFIG, 8'h2d);
        cmp8({6'h00, lock, start}, 8'h03);
        u_host.wr(MRM_ADDR_CONFIG, 8'h10);
        cmp8({6'h00, lock, start}, 8'h01);
    endtask
    task automatic t_power_reset;
        u_host.wr(MRM_ADDR_MASK, 8'hf0);
        u_host.wr(MRM_ADDR_CONFIG, 8'h0b);
        pulse(8'h01);
        pin_after(1'b0);
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        cmp8({7'h00, int_b}, 8'h01);
        cmp8({6'h00, lock, start}, 8'h01);
        cmp8(status, 8'h00);
        chk_rd(MRM_ADDR_CONFIG, 8'h25);
        chk_rd(MRM_ADDR_MASK, 8'h00);
        chk_rd(MRM_ADDR_STATUS_COPY, 8'h00);
    endtask
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        ev = 8'h00;
        repeat (16) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_reset_values;
        t_identity;
        t_reserved;
        t_clear_holds;
        t_enable;
        t_lock;
        t_power_reset;
        print_verdict;
    end
endmodule
